/* nps_interlock.sv */
// Summary of operation
// - lever in neutral keeps the starter-inhibit output low.
// - lever in forward or reverse drives starter-inhibit high.
// - during initialization every output is held inactive.
// - after initialization hold neutral until lever cycles through neutral to a direction.
// - standard mode: brake applied forces neutral regardless of lever.
// - standard mode: after brake release, neutral until lever cycle and reselection.
// - option one: request at standstill applies brake output and forces neutral.
// - option one: after request withdrawn keep brake applied until service brake press.
// - option one: service press after withdrawal releases brake and permits direction.
// - option two: request applies brake, withdrawal releases at once, neutral until cycle.
// - immediate option permits direction as soon as parking brake releases.
// - either option permits direction on completed lever cycle, or on service press after brake release.
// - push-button engagement enable only honoured in option one.
`timescale 1ns/10ps
`default_nettype none
`include "nps_defines.svh"

module nps_interlock #(
  parameter int INIT_CYCLES = `NPS_INIT_CYCLES
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic lever_fwd_i,
  input  wire logic lever_rev_i,
  input  wire logic brake_state_i,
  input  wire logic brake_req_i,
  input  wire logic standstill_i,
  input  wire logic service_brake_i,
  input  wire logic cfg_mode0_i,
  input  wire logic cfg_mode1_i,
  input  wire logic cfg_immediate_i,
  input  wire logic cfg_either_i,
  input  wire logic cfg_short_en_i,
  output logic      start_inhibit_o,
  output logic      dir_fwd_o,
  output logic      dir_rev_o,
  output logic      brake_apply_o,
  output logic      short_engage_ok_o,
  output logic      init_done_o
);

  // ==========================================================
  // pin synchronisers
  logic [`NPS_PIN_COUNT-1:0] pins_s;

  nps_sync #(
    .WIDTH (`NPS_PIN_COUNT)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .async_i   ({cfg_short_en_i, cfg_either_i, cfg_immediate_i, cfg_mode1_i, cfg_mode0_i,
                 service_brake_i, standstill_i, brake_req_i, brake_state_i,
                 lever_rev_i, lever_fwd_i}),
    .sync_o    (pins_s)
  );

  wire logic fwd_s   = pins_s[`NPS_PIN_FWD];
  wire logic rev_s   = pins_s[`NPS_PIN_REV];
  wire logic brk_s   = pins_s[`NPS_PIN_BRK_STATE];
  wire logic req_s   = pins_s[`NPS_PIN_BRK_REQ];
  wire logic still_s = pins_s[`NPS_PIN_STANDSTILL];
  wire logic svc_s   = pins_s[`NPS_PIN_SVC_BRK];

  // ==========================================================
  // static configuration, caught while reset is held
  nps_pkg::nps_mode_t cfg_mode_q;
  logic               cfg_imm_q;
  logic               cfg_either_q;
  logic               cfg_short_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_mode_q   <= {pins_s[`NPS_PIN_CFG_MODE1], pins_s[`NPS_PIN_CFG_MODE0]};
      cfg_imm_q    <= pins_s[`NPS_PIN_CFG_IMM];
      cfg_either_q <= pins_s[`NPS_PIN_CFG_EITHER];
      cfg_short_q  <= pins_s[`NPS_PIN_CFG_SHORT];
    end
  end

  wire logic mode_std  = (cfg_mode_q == `NPS_MODE_STD);
  wire logic mode_opt1 = (cfg_mode_q == `NPS_MODE_OPT1);
  wire logic mode_opt2 = (cfg_mode_q == `NPS_MODE_OPT2);

  // ==========================================================
  // lever decode
  wire logic lever_n   = !fwd_s && !rev_s;
  wire logic lever_dir = fwd_s ^ rev_s;

  // ==========================================================
  // init counter
  logic [15:0] init_cnt_q;
  logic        init_q;
  wire  logic  init_end = (init_cnt_q == 16'(INIT_CYCLES - 1));

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      init_cnt_q <= 16'h0000;
      init_q     <= 1'b1;
    end else if (init_q) begin
      init_cnt_q <= init_cnt_q + 16'h0001;
      init_q     <= !init_end;
    end
  end

  // ==========================================================
  // brake apply output logic
  logic      apply_q;
  wire logic req_hit  = req_s && still_s;
  wire logic apply_d1 = apply_q ? (req_s || !svc_s) : req_hit;
  wire logic apply_d2 = apply_q ? req_s : req_hit;
  wire logic apply_d  = !init_q && ((mode_opt1 && apply_d1) || (mode_opt2 && apply_d2));

  // neutral forcing from the brake
  wire logic force_n = (mode_std && brk_s) ||
                       ((mode_opt1 || mode_opt2) && (apply_q || req_hit));

  // ==========================================================
  // interlock state machine
  nps_pkg::nps_state_t st_q;
  nps_pkg::nps_state_t st_d;
  logic                seen_n_q;
  logic                from_brk_q;
  wire  logic          cycled     = seen_n_q && lever_dir;
  wire  logic          either_ok  = cfg_either_q && from_brk_q && svc_s;
  wire  logic          direct_rel = mode_opt1 || cfg_imm_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      nps_pkg::NPS_ST_INIT: begin
        if (init_end) begin
          st_d = nps_pkg::NPS_ST_LOCK;
        end
      end
      nps_pkg::NPS_ST_PARK: begin
        if (!force_n) begin
          st_d = direct_rel ? nps_pkg::NPS_ST_RUN : nps_pkg::NPS_ST_LOCK;
        end
      end
      nps_pkg::NPS_ST_LOCK: begin
        if (force_n) begin
          st_d = nps_pkg::NPS_ST_PARK;
        end else if (cycled || either_ok) begin
          st_d = nps_pkg::NPS_ST_RUN;
        end
      end
      nps_pkg::NPS_ST_RUN: begin
        if (force_n) begin
          st_d = nps_pkg::NPS_ST_PARK;
        end
      end
      default: begin
        st_d = nps_pkg::NPS_ST_INIT;
      end
    endcase
  end

  wire logic seen_n_d   = (st_q == nps_pkg::NPS_ST_LOCK) && (seen_n_q || lever_n);
  wire logic from_brk_d = (st_q == nps_pkg::NPS_ST_PARK) ||
                          ((st_q == nps_pkg::NPS_ST_LOCK) && from_brk_q);
  wire logic run_ok     = (st_q == nps_pkg::NPS_ST_RUN) && !force_n && !init_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_q       <= nps_pkg::NPS_ST_INIT;
      seen_n_q   <= 1'b0;
      from_brk_q <= 1'b0;
      apply_q    <= 1'b0;
    end else begin
      st_q       <= st_d;
      seen_n_q   <= seen_n_d;
      from_brk_q <= from_brk_d;
      apply_q    <= apply_d;
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      start_inhibit_o   <= 1'b0;
      dir_fwd_o         <= 1'b0;
      dir_rev_o         <= 1'b0;
      short_engage_ok_o <= 1'b0;
      init_done_o       <= 1'b0;
    end else begin
      start_inhibit_o   <= !init_q && lever_dir;
      dir_fwd_o         <= run_ok && fwd_s && !rev_s;
      dir_rev_o         <= run_ok && rev_s && !fwd_s;
      short_engage_ok_o <= !init_q && mode_opt1 && cfg_short_q;
      init_done_o       <= !init_q;
    end
  end

  assign brake_apply_o = apply_q;

  // ==========================================================
  // assertions
  sequence s_neutral_seen;
    (st_q == nps_pkg::NPS_ST_LOCK) && lever_n && !force_n;
  endsequence

  sequence s_dir_select;
    (st_q == nps_pkg::NPS_ST_LOCK) && fwd_s && !rev_s && !force_n && !init_q;
  endsequence

  property p_no_inhibit;
    @(posedge sys_clk_i) disable iff (rst_i)
      lever_n |=> !start_inhibit_o;
  endproperty
  a_no_inhibit: assert property (p_no_inhibit) else $error("inhibit in neutral");

  property p_inhibit;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!init_q && lever_dir) |=> start_inhibit_o;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit missing");

  property p_init_quiet;
    @(posedge sys_clk_i) disable iff (rst_i)
      init_q |=> !dir_fwd_o && !dir_rev_o && !brake_apply_o && !start_inhibit_o;
  endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("output active in init");

  property p_init_lock;
    @(posedge sys_clk_i) disable iff (rst_i)
      $fell(init_q) |-> (st_q == nps_pkg::NPS_ST_LOCK) ##1 !dir_fwd_o && !dir_rev_o;
  endproperty
  a_init_lock: assert property (p_init_lock) else $error("no lock after init");

  property p_std_force;
    @(posedge sys_clk_i) disable iff (rst_i)
      (mode_std && brk_s) |=> !dir_fwd_o && !dir_rev_o;
  endproperty
  a_std_force: assert property (p_std_force) else $error("drive against brake");

  property p_opt1_apply;
    @(posedge sys_clk_i) disable iff (rst_i)
      (mode_opt1 && req_hit && !init_q) |=> brake_apply_o ##1 !dir_fwd_o;
  endproperty
  a_opt1_apply: assert property (p_opt1_apply) else $error("brake not applied");

  property p_opt1_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
      (mode_opt1 && brake_apply_o && !svc_s && !init_q) |=> brake_apply_o;
  endproperty
  a_opt1_hold: assert property (p_opt1_hold) else $error("brake dropped early");

  property p_opt1_rel;
    @(posedge sys_clk_i) disable iff (rst_i)
      (mode_opt1 && brake_apply_o && !req_s && svc_s) |=> !brake_apply_o;
  endproperty
  a_opt1_rel: assert property (p_opt1_rel) else $error("brake not released");

  property p_opt2_rel;
    @(posedge sys_clk_i) disable iff (rst_i)
      (mode_opt2 && brake_apply_o && !req_s) |=> !brake_apply_o;
  endproperty
  a_opt2_rel: assert property (p_opt2_rel) else $error("option two release late");

  property p_short_gate;
    @(posedge sys_clk_i) disable iff (rst_i)
      short_engage_ok_o |-> mode_opt1 && cfg_short_q;
  endproperty
  a_short_gate: assert property (p_short_gate) else $error("short enable outside opt1");

  property p_cycle;
    @(posedge sys_clk_i) disable iff (rst_i)
      s_neutral_seen ##1 s_dir_select |=> (st_q == nps_pkg::NPS_ST_RUN) ##1 dir_fwd_o;
  endproperty
  a_cycle: assert property (p_cycle) else $error("lever cycle not honoured");

endmodule // nps_interlock

`default_nettype wire

/* nps_defines.svh */
`ifndef NPS_DEFINES_SVH
`define NPS_DEFINES_SVH

// ==========================================================
// timing
`define NPS_CLK_FREQ_MHZ   10
`define NPS_INIT_TIME_US   100
`define NPS_INIT_CYCLES    ((`NPS_INIT_TIME_US) * (`NPS_CLK_FREQ_MHZ))

// ==========================================================
// brake mode codes and config reset values
`define NPS_MODE_STD       2'h0
`define NPS_MODE_OPT1      2'h1
`define NPS_MODE_OPT2      2'h2
`define NPS_CFG_MODE_RST   2'h0

// ==========================================================
// synchronised pin vector positions
`define NPS_PIN_FWD        0
`define NPS_PIN_REV        1
`define NPS_PIN_BRK_STATE  2
`define NPS_PIN_BRK_REQ    3
`define NPS_PIN_STANDSTILL 4
`define NPS_PIN_SVC_BRK    5
`define NPS_PIN_CFG_MODE0  6
`define NPS_PIN_CFG_MODE1  7
`define NPS_PIN_CFG_IMM    8
`define NPS_PIN_CFG_EITHER 9
`define NPS_PIN_CFG_SHORT  10
`define NPS_PIN_COUNT      11

`endif

/* nps_pkg.sv */
package nps_pkg;

  // ==========================================================
  // interlock states, one-hot
  typedef enum logic [3:0] {
    NPS_ST_INIT = 4'h1,
    NPS_ST_PARK = 4'h2,
    NPS_ST_LOCK = 4'h4,
    NPS_ST_RUN  = 4'h8
  } nps_state_t;

  typedef logic [1:0] nps_mode_t;

endpackage

/* nps_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module nps_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // ==========================================================
  // two-flop synchroniser
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge sys_clk_i) begin
    meta_q <= async_i;
    sync_o <= meta_q;
  end

endmodule // nps_sync

`default_nettype wire

/* nps_far_side.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// lever, brake switches, starter relay and brake actuator
module nps_far_side (
  input  wire logic       sys_clk_i,
  input  wire logic [5:0] cmd_i,
  input  wire logic       start_inhibit_i,
  input  wire logic       brake_apply_i,
  output logic      [5:0] pins_o,
  output logic            relay_closed_o,
  output logic            brake_held_o
);
  logic [5:0] pins_q = 6'h00;

  // switches settle one edge after the command
  always @(posedge sys_clk_i) begin
    pins_q <= cmd_i;
  end

  assign pins_o         = pins_q;
  // normally closed relay opens while driven
  assign relay_closed_o = !start_inhibit_i;
  assign brake_held_o   = brake_apply_i;
endmodule // nps_far_side

`default_nettype wire

/* nps_interlock_tb.sv */
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module nps_interlock_tb;
  localparam int INIT = 4;

  // ==========================================================
  // signals
  logic       sys_clk_i   = 1'b0;
  logic       rst_i       = 1'b1;
  logic [4:0] cfg         = 5'h00;
  logic [5:0] cmd         = 6'h00;
  wire  [5:0] pins;
  wire        inh, fwd, rev, apply, short_ok, done, relay, held;
  int         error_cnt   = 0;
  int         check_count = 0;

  initial forever #50 sys_clk_i = ~sys_clk_i;

  nps_far_side far (
    .sys_clk_i       (sys_clk_i),
    .cmd_i           (cmd),
    .start_inhibit_i (inh),
    .brake_apply_i   (apply),
    .pins_o          (pins),
    .relay_closed_o  (relay),
    .brake_held_o    (held)
  );

  nps_interlock #(.INIT_CYCLES(INIT)) uut (
    .sys_clk_i         (sys_clk_i),
    .rst_i             (rst_i),
    .lever_fwd_i       (pins[0]),
    .lever_rev_i       (pins[1]),
    .brake_state_i     (pins[2]),
    .brake_req_i       (pins[3]),
    .standstill_i      (pins[4]),
    .service_brake_i   (pins[5]),
    .cfg_mode0_i       (cfg[0]),
    .cfg_mode1_i       (cfg[1]),
    .cfg_immediate_i   (cfg[2]),
    .cfg_either_i      (cfg[3]),
    .cfg_short_en_i    (cfg[4]),
    .start_inhibit_o   (inh),
    .dir_fwd_o         (fwd),
    .dir_rev_o         (rev),
    .brake_apply_o     (apply),
    .short_engage_ok_o (short_ok),
    .init_done_o       (done)
  );

  // ==========================================================
  // tasks
  task automatic conclude();
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // pins: {service, standstill, request, brake, rev, fwd}
  task automatic set_pins(input logic [5:0] v);
    @(posedge sys_clk_i);
    cmd <= v;
    repeat (7) @(posedge sys_clk_i);
    #1;
  endtask

  // cfg: {short, either, immediate, mode1, mode0}
  task automatic restart(input logic [4:0] c);
    int n;
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    cfg   <= c;
    cmd   <= 6'h01;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (n = 0; n < INIT; n++) begin
      @(posedge sys_clk_i);
      #1;
      `CHK("init_outs", 6'h00, {inh, fwd, rev, apply, short_ok, done})
    end
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n == 20) begin
      error_cnt++;
      conclude();
    end
  endtask

  // ==========================================================
  // sequence
  initial begin
    restart(5'h00);
    set_pins(6'h01);
    `CHK("inhibit_fwd", 1'b1, inh)
    `CHK("fwd_after_init", 1'b0, fwd)
    set_pins(6'h00);
    `CHK("inhibit_neutral", 1'b0, inh)
    `CHK("relay_neutral", 1'b1, relay)
    set_pins(6'h01);
    `CHK("fwd_cycled", 1'b1, fwd)
    @(posedge sys_clk_i);
    cfg <= 5'h01;
    set_pins(6'h05);
    `CHK("brake_fwd", 1'b0, fwd)
    `CHK("brake_inhibit", 1'b1, inh)
    set_pins(6'h01);
    `CHK("released_fwd", 1'b0, fwd)
    set_pins(6'h00);
    set_pins(6'h02);
    `CHK("rev_cycled", 1'b1, rev)

    restart(5'h11);
    set_pins(6'h00);
    `CHK("short_opt1", 1'b1, short_ok)
    set_pins(6'h01);
    set_pins(6'h19);
    `CHK("apply_req", 2'h2, {held, fwd})
    set_pins(6'h01);
    `CHK("apply_kept", 2'h2, {held, fwd})
    set_pins(6'h21);
    `CHK("apply_svc", 2'h1, {held, fwd})

    restart(5'h12);
    set_pins(6'h00);
    `CHK("short_opt2", 1'b0, short_ok)
    set_pins(6'h01);
    set_pins(6'h19);
    `CHK("apply_req2", 2'h2, {held, fwd})
    set_pins(6'h01);
    `CHK("apply_drop2", 2'h0, {held, fwd})
    set_pins(6'h00);
    set_pins(6'h01);
    `CHK("fwd_cycled2", 1'b1, fwd)

    // immediate option, then either option
    for (int k = 0; k < 2; k++) begin
      restart(k == 0 ? 5'h04 : 5'h08);
      set_pins(6'h00);
      set_pins(6'h01);
      set_pins(6'h05);
      set_pins(6'h01);
      `CHK("brake_release", (k == 0), fwd)
      set_pins(6'h21);
      `CHK("svc_release", 1'b1, fwd)
    end

    // mode code three: no parking-brake forcing
    restart(5'h03);
    set_pins(6'h00);
    set_pins(6'h01);
    set_pins(6'h19);
    `CHK("no_brake_mode", 2'h1, {held, fwd})
    conclude();
  end
endmodule // nps_interlock_tb

`default_nettype wire
